// [csd_pkg.sv]
`default_nettype none
package csd_pkg;

    localparam int NUM_SOCKETS_DEF = 2;
    localparam int SYNC_STAGES     = 2;

    // Battery condition, one-hot
    typedef enum logic [2:0] {
        BATT_GOOD = 3'b001,
        BATT_WEAK = 3'b010,
        BATT_DEAD = 3'b100
    } csd_batt_t;

    localparam csd_batt_t BATT_RESET = BATT_GOOD;

    // Raw card status pins of one socket
    typedef struct packed {
        logic battery_sense_first;
        logic battery_sense_second;
        logic card_detect_first;
        logic card_detect_second;
    } csd_pins_t;

    localparam csd_pins_t PINS_RESET = 4'hf;

    // Per-socket configuration
    typedef struct packed {
        logic io_mode;
        logic dma_mode;
        logic batt_evt_en;
        logic detect_evt_en;
    } csd_cfg_t;

    // Per-socket decoded status
    typedef struct packed {
        csd_batt_t  batt_state;
        logic [1:0] card_detect;
        logic       inserted;
        logic       card_status_change_in;
        logic       ring_detect_in;
        logic       dma_req;
        logic       batt_evt;
        logic       detect_evt;
    } csd_status_t;

    localparam csd_status_t STATUS_RESET = {BATT_RESET, 2'h3, 1'b0, 1'b0, 1'b0,
                                            1'b0, 1'b0, 1'b0};

endpackage
`default_nettype wire

// [csd_top.sv]
// Functional notes
// R1: A battery-backed memory card drives both battery-sense lines with battery state.
// R2: Both battery-sense inputs high reports battery good.
// R3: Second low with first high reports battery weak, needs replacing.
// R4: First battery-sense input low reports battery dead, contents lost.
// R5: Battery condition readable as status; change event gated by software enable.
// R6: In I/O mode the first battery-sense pin is the status-change input.
// R7: First battery-sense pin serves as ring-detect for modem cards.
// R8: Second battery-sense pin is binary audio only in 16-bit I/O mode.
// R9: Audio of both sockets merged onto one speaker output pin.
// R10: In DMA mode card asserts second battery-sense line as DMA request.
// R11: Card grounds both card-detect lines internally, pulling them low.
// R12: Low card-detect levels mean insertion; both lines readable as status.
// R13: Two independent sockets, each with a full set of status inputs.
// R14: Socket audio inputs combined by exclusive-OR before the speaker output.
// R15: Every card status input passes two flip-flops before decode or compare.
`timescale 1ns/1ps
`default_nettype none
module csd_top #(
    parameter int NUM_SOCKETS = csd_pkg::NUM_SOCKETS_DEF
) (
    input  wire logic                                 clock,
    input  wire logic                                 resetn,
    input  wire csd_pkg::csd_pins_t [NUM_SOCKETS-1:0] pins,
    input  wire csd_pkg::csd_cfg_t  [NUM_SOCKETS-1:0] cfg,
    output var  csd_pkg::csd_status_t [NUM_SOCKETS-1:0] status,
    output var  logic                                 merged_audio_out
);
    import csd_pkg::*;

    logic [NUM_SOCKETS-1:0] audio_bits;
    logic [NUM_SOCKETS-1:0] audio_raw;
    logic [NUM_SOCKETS-1:0] io_mode_vec;

    genvar i;
    generate
        for (i = 0; i < NUM_SOCKETS; i++) begin : g_sock // R13
            csd_pins_t  sync1_r;
            csd_pins_t  sync2_r;
            csd_batt_t  batt_nxt;
            logic       inserted_nxt;
            csd_batt_t  batt_r;
            logic       batt_evt_r;
            logic       status_chg_r;
            logic       ring_r;
            logic       dma_req_r;
            logic [1:0] detect_r;
            logic       inserted_r;
            logic       detect_evt_r;

            // Two-stage synchroniser; stage one feeds only stage two
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    sync1_r <= PINS_RESET;
                    sync2_r <= PINS_RESET;
                end else begin
                    sync1_r <= pins[i]; // R15
                    sync2_r <= sync1_r; // R15
                end
            end

            always_comb begin
                case ({sync2_r.battery_sense_first, sync2_r.battery_sense_second})
                    2'h3:    batt_nxt = BATT_GOOD; // R2
                    2'h2:    batt_nxt = BATT_WEAK; // R3
                    default: batt_nxt = BATT_DEAD; // R4
                endcase
            end

            assign inserted_nxt = !sync2_r.card_detect_first &&
                                  !sync2_r.card_detect_second; // R12

            // Battery decode and change event
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    batt_r     <= BATT_RESET;
                    batt_evt_r <= 1'b0;
                end else begin
                    batt_r     <= batt_nxt; // R5
                    batt_evt_r <= cfg[i].batt_evt_en && !cfg[i].io_mode &&
                                  (batt_nxt != batt_r); // R5
                end
            end

            // I/O card reuse of the battery-sense pins
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    status_chg_r <= 1'b0;
                    ring_r       <= 1'b0;
                    dma_req_r    <= 1'b0;
                end else begin
                    status_chg_r <= cfg[i].io_mode && !sync2_r.battery_sense_first; // R6
                    ring_r       <= cfg[i].io_mode && !sync2_r.battery_sense_first; // R7
                    dma_req_r    <= cfg[i].dma_mode && sync2_r.battery_sense_second; // R10
                end
            end

            // Card detect status; the event fires on insertion and on removal
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    detect_r     <= 2'h3;
                    inserted_r   <= 1'b0;
                    detect_evt_r <= 1'b0;
                end else begin
                    detect_r     <= {sync2_r.card_detect_second,
                                     sync2_r.card_detect_first}; // R12
                    inserted_r   <= inserted_nxt; // R12
                    detect_evt_r <= cfg[i].detect_evt_en && (inserted_nxt != inserted_r); // R5 R12
                end
            end

            assign status[i] = '{batt_state:            batt_r,
                                 card_detect:           detect_r,
                                 inserted:              inserted_r,
                                 card_status_change_in: status_chg_r,
                                 ring_detect_in:        ring_r,
                                 dma_req:               dma_req_r,
                                 batt_evt:              batt_evt_r,
                                 detect_evt:            detect_evt_r};

            // Audio only counts in I/O mode
            assign audio_bits[i]  = cfg[i].io_mode && sync2_r.battery_sense_second; // R8
            assign audio_raw[i]   = pins[i].battery_sense_second;
            assign io_mode_vec[i] = cfg[i].io_mode;

            sequence s_good_in;
                pins[i].battery_sense_first && pins[i].battery_sense_second;
            endsequence
            sequence s_weak_in;
                pins[i].battery_sense_first && !pins[i].battery_sense_second;
            endsequence
            sequence s_removed_in;
                pins[i].card_detect_first || pins[i].card_detect_second;
            endsequence
            sequence s_batt_change;
                $past(resetn) && $past(cfg[i].batt_evt_en) && !$past(cfg[i].io_mode) &&
                batt_r != $past(batt_r);
            endsequence
            sequence s_detect_change;
                $past(resetn) && $past(cfg[i].detect_evt_en) && inserted_r != $past(inserted_r);
            endsequence

            a_batt_good_state: assert property (@(posedge clock) disable iff (!resetn) // R2
                s_good_in ##1 resetn [*2] |=> batt_r == BATT_GOOD)
                else $error("battery good not reported");

            a_batt_weak_state: assert property (@(posedge clock) disable iff (!resetn) // R3
                s_weak_in ##1 resetn [*2] |=> batt_r == BATT_WEAK)
                else $error("battery weak not reported");

            a_batt_dead_state: assert property (@(posedge clock) disable iff (!resetn) // R4
                !pins[i].battery_sense_first ##3 1 |-> batt_r == BATT_DEAD)
                else $error("battery dead not reported");

            a_batt_evt_cause: assert property (@(posedge clock) disable iff (!resetn) // R5
                batt_evt_r |-> $past(cfg[i].batt_evt_en) && !$past(cfg[i].io_mode) &&
                               batt_r != $past(batt_r))
                else $error("battery event without enabled change");

            a_batt_evt_fire: assert property (@(posedge clock) disable iff (!resetn) // R5
                s_batt_change |-> batt_evt_r)
                else $error("battery change without event");

            a_status_chg_io: assert property (@(posedge clock) disable iff (!resetn) // R6
                ##3 status_chg_r ==
                    ($past(cfg[i].io_mode) && !$past(pins[i].battery_sense_first, 3)))
                else $error("status change input wrong");

            a_ring_follow: assert property (@(posedge clock) disable iff (!resetn) // R7
                ##3 ring_r ==
                    ($past(cfg[i].io_mode) && !$past(pins[i].battery_sense_first, 3)))
                else $error("ring detect input wrong");

            a_dma_req_map: assert property (@(posedge clock) disable iff (!resetn) // R10
                ##3 dma_req_r ==
                    ($past(cfg[i].dma_mode) && $past(pins[i].battery_sense_second, 3)))
                else $error("DMA request wrong");

            a_dma_refused: assert property (@(posedge clock) disable iff (!resetn) // R10
                !$past(cfg[i].dma_mode) |-> !dma_req_r)
                else $error("DMA request outside DMA mode");

            a_insert_detect: assert property (@(posedge clock) disable iff (!resetn) // R12
                (!pins[i].card_detect_first && !pins[i].card_detect_second) [*3]
                |=> inserted_r)
                else $error("insertion not reported");

            a_remove_detect: assert property (@(posedge clock) disable iff (!resetn) // R12
                s_removed_in ##3 1 |-> !inserted_r)
                else $error("removal not reported");

            a_detect_evt_cause: assert property (@(posedge clock) disable iff (!resetn) // R5
                detect_evt_r |-> $past(cfg[i].detect_evt_en) &&
                                 inserted_r != $past(inserted_r))
                else $error("detect event without enabled change");

            a_detect_evt_fire: assert property (@(posedge clock) disable iff (!resetn) // R5
                s_detect_change |-> detect_evt_r)
                else $error("insertion change without event");

            a_sync_depth: assert property (@(posedge clock) disable iff (!resetn) // R15
                ##3 detect_r ==
                    {$past(pins[i].card_detect_second, 3),
                     $past(pins[i].card_detect_first, 3)})
                else $error("card detect latency wrong");
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!resetn) begin
            merged_audio_out <= 1'b0;
        end else begin
            merged_audio_out <= ^audio_bits; // R9 R14
        end
    end

    a_audio_merge: assert property (@(posedge clock) disable iff (!resetn) // R9 R14
        ##3 merged_audio_out == ^($past(audio_raw, 3) & $past(io_mode_vec)))
        else $error("speaker output not exclusive-OR of sockets");

    a_audio_quiet: assert property (@(posedge clock) disable iff (!resetn) // R8
        !(|$past(io_mode_vec)) |-> !merged_audio_out)
        else $error("speaker output active without I/O mode");

endmodule
`default_nettype wire

// [csd_card_model.sv]
`timescale 1ns/1ps
`default_nettype none
module csd_card_model (
    input  wire logic              present,
    input  wire logic [1:0]        batt,
    output var  csd_pkg::csd_pins_t pins
);
    import csd_pkg::*;
    // Pulled-up lines read high while no card sits in the socket
    always_comb begin
        pins.card_detect_first    = !present;
        pins.card_detect_second   = !present;
        pins.battery_sense_first  = present ? batt[1] : 1'b1;
        pins.battery_sense_second = present ? batt[0] : 1'b1;
    end
endmodule
`default_nettype wire

// [card_socket_status_decode_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module card_socket_status_decode_tb;
    import csd_pkg::*;
    logic                    clock = 1'b0;
    logic                    resetn = 1'b0;
    logic [1:0]              present;
    logic [1:0]              batt [2];
    csd_pins_t   [1:0]       pins;
    csd_cfg_t    [1:0]       cfg;
    csd_status_t [1:0]       status;
    logic                    merged_audio_out;
    int                      num_errors = 0;
    int                      samples_checked = 0;
    for (genvar i = 0; i < 2; i++) begin : g_card
        csd_card_model csd_card_model_inst (.present(present[i]), .batt(batt[i]), .pins(pins[i]));
    end
    csd_top #(.NUM_SOCKETS(2)) csd_top_inst (.clock(clock), .resetn(resetn), .pins(pins),
        .cfg(cfg), .status(status), .merged_audio_out(merged_audio_out));
    initial begin
        forever #12.5 clock = ~clock;
    end
    // Status registers take a pin change at the third rising edge after it
    task automatic settle();
        repeat (3) @(negedge clock);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_detect();
        cfg[0].detect_evt_en = 1'b1;
        present[0] = 1'b1;
        settle();
        `CHK("card_detect", 2'h0, status[0].card_detect)
        `CHK("inserted", 1'b1, status[0].inserted)
        `CHK("detect_evt", 1'b1, status[0].detect_evt)
        `CHK("other_socket", 1'b0, status[1].inserted)
        @(negedge clock);
        `CHK("detect_evt_end", 1'b0, status[0].detect_evt)
        present[0] = 1'b0;
        settle();
        `CHK("removed", 1'b0, status[0].inserted)
        `CHK("removed_detect", 2'h3, status[0].card_detect)
        `CHK("removal_evt", 1'b1, status[0].detect_evt)
        present[0] = 1'b1;
        settle();
        `CHK("reinserted", 1'b1, status[0].inserted)
        $display("test detect done");
    endtask
    task automatic t_batt();
        logic [1:0] codes [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
        csd_batt_t  exp [4] = '{BATT_WEAK, BATT_DEAD, BATT_DEAD, BATT_GOOD};
        logic [3:0] evt = 4'hd;
        cfg[0].batt_evt_en = 1'b1;
        for (int i = 0; i < 4; i++) begin
            batt[0] = codes[i];
            settle();
            `CHK("batt_state", exp[i], status[0].batt_state)
            `CHK("batt_evt", evt[3-i], status[0].batt_evt)
        end
        cfg[0].batt_evt_en = 1'b0;
        batt[0] = 2'h2;
        settle();
        `CHK("batt_evt_masked", 1'b0, status[0].batt_evt)
        $display("test battery done");
    endtask
    task automatic t_io();
        present[1] = 1'b1;
        cfg[0].batt_evt_en = 1'b1;
        cfg[0].io_mode = 1'b1;
        cfg[1].io_mode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            batt[0] = {!i[1], i[0]};
            batt[1] = {1'b1, i[1]};
            settle();
            `CHK("status_change", i[1], status[0].card_status_change_in)
            `CHK("ring", i[1], status[0].ring_detect_in)
            `CHK("inserted_b", 1'b1, status[1].inserted)
            `CHK("detect_evt_masked", 1'b0, status[1].detect_evt)
            `CHK("batt_evt_io", 1'b0, status[0].batt_evt)
            `CHK("audio", i[0] ^ i[1], merged_audio_out)
        end
        $display("test io done");
    endtask
    task automatic t_dma();
        cfg = '0;
        cfg[0].dma_mode = 1'b1;
        batt[0] = 2'h3;
        batt[1] = 2'h3;
        settle();
        `CHK("dma_req", 1'b1, status[0].dma_req)
        `CHK("dma_off", 1'b0, status[1].dma_req)
        `CHK("audio_mem", 1'b0, merged_audio_out)
        batt[0] = 2'h2;
        settle();
        `CHK("dma_idle", 1'b0, status[0].dma_req)
        $display("test dma done");
    endtask
    initial begin
        present = 2'h0;
        batt = '{2'h3, 2'h3};
        cfg = '0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        `CHK("reset_batt", BATT_GOOD, status[0].batt_state)
        `CHK("reset_detect", 2'h3, status[0].card_detect)
        `CHK("reset_audio", 1'b0, merged_audio_out)
        t_detect();
        t_batt();
        t_io();
        t_dma();
        tally_and_finish();
    end
    initial begin
        #50000;
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
